// >>> rtl/sweie_core.sv
// sweie_core.sv: comparator interrupt-select registers and per-input edge events
// assumes: the serial interface decoder presents one-cycle access strobes,
// comparator results and group thresholds come from the comparator front end
//
// Behaviour
// (RL1) select zero: no interrupt for that input at all
// (RL2) select one: interrupt only on rise above group threshold
// (RL3) select two: interrupt only on fall below group threshold
// (RL4) select three: interrupt on crossing in either direction
// (RL5) input 23 at bits 23:22 of high register, lower inputs below
// (RL6) input 19 at bits 15:14 of high register, group 16 to 19
// (RL7) input 6 at bits 13:12 of low register, input 0 at 1:0
// (RL8) inputs 0-3 use group zero threshold, 4-7 group one
// (RL9) high register at offset 23h, reset to zero
// (RL10) every field read/write; a write affects only its own input
// (RL11) low register at offset 22h, reset zero, inputs 0 to 11
// (RL12) input 12 at bits 1:0 of high register
// (RL13) edge is a change between two consecutive samples of one input
`timescale 1ns/1ps
`include "sweie_defines.svh"
module sweie_core
  import sweie_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input sweie_access_type access,
  input wire logic [`SWEIE_NUM_INPUTS-1:0] comp_result,
  input wire logic [`SWEIE_NUM_INPUTS-1:0] sample_valid,
  output sweie_answer_type answer,
  output logic [`SWEIE_NUM_INPUTS-1:0] edge_event,
  output logic [`SWEIE_NUM_INPUTS-1:0] rise_event,
  output logic [`SWEIE_NUM_INPUTS-1:0] fall_event,
  output logic irq_pending
);

  // ==========================================================
  // reset release
  logic reset_meta_n;
  logic reset_sync_n;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reset_meta_n <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta_n <= 1'b1;
      reset_sync_n <= reset_meta_n;
    end
  end

  // ==========================================================
  // interrupt-select registers
  logic [`SWEIE_REG_WIDTH-1:0] comparator_irq_select_low;
  logic [`SWEIE_REG_WIDTH-1:0] comparator_irq_select_high;
  logic write_low;
  logic write_high;

  assign write_low = access.write && (access.addr == `SWEIE_OFFSET_SELECT_LOW); // RL11
  assign write_high = access.write && (access.addr == `SWEIE_OFFSET_SELECT_HIGH); // RL9

  // whole-word write; each field only steers its own input below
  always_ff @(posedge clock or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      comparator_irq_select_low <= `SWEIE_RESET_SELECT; // RL11
    end else if (write_low) begin
      comparator_irq_select_low <= access.wdata; // RL10
    end
  end

  always_ff @(posedge clock or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      comparator_irq_select_high <= `SWEIE_RESET_SELECT; // RL9
    end else if (write_high) begin
      comparator_irq_select_high <= access.wdata; // RL10
    end
  end

  // ==========================================================
  // read answer, one cycle after the read strobe
  always_ff @(posedge clock or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      answer <= '0;
    end else begin
      answer.valid <= access.read;
      if (!access.read) begin
        answer.rdata <= `SWEIE_READ_UNMAPPED;
      end else if (access.addr == `SWEIE_OFFSET_SELECT_LOW) begin
        answer.rdata <= comparator_irq_select_low; // RL10
      end else if (access.addr == `SWEIE_OFFSET_SELECT_HIGH) begin
        answer.rdata <= comparator_irq_select_high; // RL10
      end else begin
        answer.rdata <= `SWEIE_READ_UNMAPPED;
      end
    end
  end

  // ==========================================================
  // per-input edge detection and select decode
  logic [`SWEIE_NUM_INPUTS-1:0] last_sample;
  logic [`SWEIE_NUM_INPUTS-1:0] have_sample;
  logic [`SWEIE_NUM_INPUTS-1:0] next_edge;
  logic [`SWEIE_NUM_INPUTS-1:0] next_rise;
  logic [`SWEIE_NUM_INPUTS-1:0] next_fall;
  sweie_select_type select [`SWEIE_NUM_INPUTS];

  genvar i;
  generate
    for (i = 0; i < `SWEIE_NUM_INPUTS; i++) begin : g_input
      logic rose;
      logic fell;
      // comp_result[i] is already compared against group i/4 threshold
      if (i < `SWEIE_INPUTS_PER_REG) begin : g_low
        assign select[i] = comparator_irq_select_low[2*i+1:2*i]; // RL7 RL8
      end else begin : g_high
        assign select[i] =
          comparator_irq_select_high[2*(i-`SWEIE_INPUTS_PER_REG)+1:
                                     2*(i-`SWEIE_INPUTS_PER_REG)]; // RL5 RL6 RL12
      end

      // first sample after reset only primes the history, no false edge
      assign rose = sample_valid[i] && have_sample[i] && comp_result[i] && !last_sample[i]; // RL13
      assign fell = sample_valid[i] && have_sample[i] && !comp_result[i] && last_sample[i]; // RL13

      always_comb begin
        next_rise[i] = 1'b0;
        next_fall[i] = 1'b0;
        unique case (select[i])
          `SWEIE_SEL_NONE: next_rise[i] = 1'b0; // RL1
          `SWEIE_SEL_RISE: next_rise[i] = rose; // RL2
          `SWEIE_SEL_FALL: next_fall[i] = fell; // RL3
          `SWEIE_SEL_BOTH: begin
            next_rise[i] = rose; // RL4
            next_fall[i] = fell; // RL4
          end
        endcase
        next_edge[i] = next_rise[i] | next_fall[i];
      end

      always_ff @(posedge clock or negedge reset_sync_n) begin
        if (!reset_sync_n) begin
          last_sample[i] <= 1'b0;
          have_sample[i] <= 1'b0;
        end else if (sample_valid[i]) begin
          last_sample[i] <= comp_result[i];
          have_sample[i] <= 1'b1;
        end
      end

      // ==========================================================
      // per-input checks
      // every input carries the same checks, so a slip in one field shows up

      a_gen_none: assert property (@(posedge clock) disable iff (!reset_sync_n)
        (select[i] == `SWEIE_SEL_NONE) |=> !edge_event[i]) // RL1
        else $error("event on an input whose select is none");

      a_gen_rise_hit: assert property (@(posedge clock) disable iff (!reset_sync_n)
        (select[i] == `SWEIE_SEL_RISE && rose) |=> rise_event[i]) // RL2
        else $error("rise missed with rise select");

      a_gen_rise_only: assert property (@(posedge clock) disable iff (!reset_sync_n)
        (select[i] == `SWEIE_SEL_RISE) |=> !fall_event[i]) // RL2
        else $error("fall event with rise select");

      a_gen_fall_hit: assert property (@(posedge clock) disable iff (!reset_sync_n)
        (select[i] == `SWEIE_SEL_FALL && fell) |=> fall_event[i]) // RL3
        else $error("fall missed with fall select");

      a_gen_fall_only: assert property (@(posedge clock) disable iff (!reset_sync_n)
        (select[i] == `SWEIE_SEL_FALL) |=> !rise_event[i]) // RL3
        else $error("rise event with fall select");

      a_gen_both_rise: assert property (@(posedge clock) disable iff (!reset_sync_n)
        (select[i] == `SWEIE_SEL_BOTH && rose) |=> rise_event[i]) // RL4
        else $error("rise missed with both select");

      a_gen_both_fall: assert property (@(posedge clock) disable iff (!reset_sync_n)
        (select[i] == `SWEIE_SEL_BOTH && fell) |=> fall_event[i]) // RL4
        else $error("fall missed with both select");

      // judged on the raw inputs, not on rose and fell, so the detector is checked too
      a_gen_no_false: assert property (@(posedge clock) disable iff (!reset_sync_n)
        !(sample_valid[i] && have_sample[i] && (comp_result[i] != last_sample[i]))
        |=> !edge_event[i]) // RL13
        else $error("event without a change between samples");

      a_gen_one_way: assert property (@(posedge clock) disable iff (!reset_sync_n)
        !(rise_event[i] && fall_event[i])) // RL13
        else $error("rise and fall in one cycle");

      a_gen_history: assert property (@(posedge clock) disable iff (!reset_sync_n)
        sample_valid[i] |=> last_sample[i] == $past(comp_result[i])) // RL13
        else $error("sample history not updated");

      if (i < `SWEIE_INPUTS_PER_REG) begin : g_low_check
        a_gen_low_field: assert property (@(posedge clock) disable iff (!reset_sync_n)
          write_low |=> select[i] == $past(access.wdata[2*i+1:2*i])) // RL7
          else $error("low register field lands on wrong input");
      end else begin : g_high_check
        a_gen_high_field: assert property (@(posedge clock) disable iff (!reset_sync_n)
          write_high |=> select[i] == $past(access.wdata[2*(i-`SWEIE_INPUTS_PER_REG)+1:
                                                         2*(i-`SWEIE_INPUTS_PER_REG)]))
          // RL5
          else $error("high register field lands on wrong input");
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      edge_event <= '0;
      rise_event <= '0;
      fall_event <= '0;
      irq_pending <= 1'b0;
    end else begin
      edge_event <= next_edge;
      rise_event <= next_rise;
      fall_event <= next_fall;
      irq_pending <= |next_edge;
    end
  end

  // ==========================================================
  // checks
  a_none_silent: assert property (@(posedge clock) disable iff (!reset_sync_n)
    (select[0] == `SWEIE_SEL_NONE) |=> !edge_event[0]) // RL1
    else $error("input 0 event while select is none");
  a_rise_only: assert property (@(posedge clock) disable iff (!reset_sync_n)
    (select[5] == `SWEIE_SEL_RISE && sample_valid[5] && have_sample[5]
     && comp_result[5] && !last_sample[5]) |=> rise_event[5] && !fall_event[5]) // RL2
    else $error("input 5 rise missed");
  a_fall_only: assert property (@(posedge clock) disable iff (!reset_sync_n)
    (select[19] == `SWEIE_SEL_FALL) |=> !rise_event[19]) // RL3
    else $error("input 19 rise with fall select");
  a_both_edges: assert property (@(posedge clock) disable iff (!reset_sync_n)
    (select[23] == `SWEIE_SEL_BOTH && sample_valid[23] && have_sample[23]
     && (comp_result[23] != last_sample[23])) |=> edge_event[23]) // RL4
    else $error("input 23 crossing missed");
  a_high_layout: assert property (@(posedge clock) disable iff (!reset_sync_n)
    write_high |=> select[23] == $past(access.wdata[23:22])
    && select[19] == $past(access.wdata[15:14])
    && select[12] == $past(access.wdata[1:0])) // RL5
    else $error("high register field layout wrong");
  a_low_layout: assert property (@(posedge clock) disable iff (!reset_sync_n)
    write_low |=> select[6] == $past(access.wdata[13:12])
    && select[0] == $past(access.wdata[1:0])) // RL7
    else $error("low register field layout wrong");
  a_write_isolated: assert property (@(posedge clock) disable iff (!reset_sync_n)
    write_high |=> $stable(comparator_irq_select_low)) // RL10
    else $error("high write disturbed low register");
  a_read_back: assert property (@(posedge clock) disable iff (!reset_sync_n)
    (access.read && access.addr == `SWEIE_OFFSET_SELECT_HIGH && !write_high)
    |=> answer.valid && answer.rdata == comparator_irq_select_high) // RL9
    else $error("high register read back wrong");
  a_no_event_idle: assert property (@(posedge clock) disable iff (!reset_sync_n)
    !sample_valid[12] |=> !edge_event[12]) // RL13
    else $error("event without a new sample");

  a_low_isolated: assert property (@(posedge clock) disable iff (!reset_sync_n)
    write_low |=> $stable(comparator_irq_select_high)) // RL10
    else $error("low write disturbed high register");

  a_read_low: assert property (@(posedge clock) disable iff (!reset_sync_n)
    (access.read && access.addr == `SWEIE_OFFSET_SELECT_LOW && !write_low)
    |=> answer.valid && answer.rdata == comparator_irq_select_low) // RL11
    else $error("low register read back wrong");

  // unmapped reads still answer, so the host never waits on a missing reply
  a_read_unmapped: assert property (@(posedge clock) disable iff (!reset_sync_n)
    (access.read && access.addr != `SWEIE_OFFSET_SELECT_LOW
     && access.addr != `SWEIE_OFFSET_SELECT_HIGH)
    |=> answer.valid && answer.rdata == `SWEIE_READ_UNMAPPED) // RL10
    else $error("unmapped read answer wrong");

  a_answer_idle: assert property (@(posedge clock) disable iff (!reset_sync_n)
    !access.read |=> !answer.valid && answer.rdata == `SWEIE_READ_UNMAPPED) // RL10
    else $error("answer without a read");

  a_irq_follows: assert property (@(posedge clock) disable iff (!reset_sync_n)
    (|edge_event) |-> irq_pending) // RL4
    else $error("edge event without pending interrupt");

endmodule

// >>> inc/sweie_defines.svh
// sweie_defines.svh: offsets, field layout, reset values and select codes
// assumes: included by the package and the design files by bare name
`ifndef SWEIE_DEFINES_SVH
`define SWEIE_DEFINES_SVH
`define SWEIE_NUM_INPUTS 24
`define SWEIE_INPUTS_PER_REG 12
`define SWEIE_GROUP_SIZE 4
`define SWEIE_NUM_GROUPS 6
`define SWEIE_REG_WIDTH 24
`define SWEIE_ADDR_WIDTH 6
`define SWEIE_FIELD_WIDTH 2
`define SWEIE_OFFSET_SELECT_LOW 6'h22
`define SWEIE_OFFSET_SELECT_HIGH 6'h23
`define SWEIE_RESET_SELECT 24'h000000
`define SWEIE_READ_UNMAPPED 24'h000000
`define SWEIE_SEL_NONE 2'h0
`define SWEIE_SEL_RISE 2'h1
`define SWEIE_SEL_FALL 2'h2
`define SWEIE_SEL_BOTH 2'h3
`endif

// >>> inc/sweie_pkg.sv
// sweie_pkg.sv: types shared by the switch edge interrupt enable block
// assumes: sweie_defines.svh on the include path
`include "sweie_defines.svh"
package sweie_pkg;
  typedef logic [`SWEIE_FIELD_WIDTH-1:0] sweie_select_type;

  // one register access from the serial interface decoder
  typedef struct packed {
    logic write;
    logic read;
    logic [`SWEIE_ADDR_WIDTH-1:0] addr;
    logic [`SWEIE_REG_WIDTH-1:0] wdata;
  } sweie_access_type;

  // read answer towards the serial interface shifter
  typedef struct packed {
    logic valid;
    logic [`SWEIE_REG_WIDTH-1:0] rdata;
  } sweie_answer_type;
endpackage

// >>> verification/sweie_host_model.sv
// sweie_host_model.sv: host register master for the select registers
// assumes: tasks are called from the bench at the falling clock edge
`timescale 1ns/1ps
module sweie_host_model
  import sweie_pkg::*;
(
  input wire logic clock,
  output sweie_access_type access,
  input sweie_answer_type answer
);
  // ====
  // host accesses, one cycle each, taken at the rising edge
  initial access = '0;
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    access = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    access = '0;
    @(negedge clock);
  endtask
  // answer stands one cycle only, so it is taken at the very next falling edge
  task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic ok);
    access = '{1'b0, 1'b1, a, 24'h000000};
    @(negedge clock);
    access = '0;
    ok = answer.valid;
    d = answer.rdata;
    @(negedge clock);
  endtask
endmodule

// >>> verification/tb_switch_edge_interrupt_enables.sv
// tb_switch_edge_interrupt_enables.sv: self-checking bench for sweie_core
// assumes: sweie_pkg compiled first, host model drives the register port
`timescale 1ns/1ps
module tb_switch_edge_interrupt_enables;
  import sweie_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [23:0] comp_result = 24'h000000;
  logic [23:0] sample_valid = 24'h000000;
  sweie_access_type access;
  sweie_answer_type answer;
  logic [23:0] edge_event, rise_event, fall_event;
  logic irq_pending;
  int n_fail = 0;
  int total_checks = 0;
  initial forever #2.5 clock = ~clock;
  sweie_host_model sweie_host_model_inst (.clock(clock), .access(access), .answer(answer));
  sweie_core sweie_core_inst (.clock(clock), .resetn(resetn), .access(access),
    .comp_result(comp_result), .sample_valid(sample_valid), .answer(answer),
    .edge_event(edge_event), .rise_event(rise_event), .fall_event(fall_event),
    .irq_pending(irq_pending));
  // ====
  // checking helpers
  task automatic test_done;
    $display("checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] d;
    logic ok;
    sweie_host_model_inst.rd(a, d, ok);
    chk("read valid", 24'h000001, {23'h000000, ok});
    chk("read data", exp, d);
  endtask
  // all inputs sampled together, so a stray field shows as an extra event bit
  task automatic smp(input logic v, input logic [23:0] r, input logic [23:0] f);
    comp_result = {24{v}};
    sample_valid = 24'hFFFFFF;
    @(negedge clock);
    sample_valid = 24'h000000;
    chk("rise", r, rise_event);
    chk("fall", f, fall_event);
    chk("edge", r | f, edge_event);
    chk("irq", {23'h000000, |(r | f)}, {23'h000000, irq_pending});
    @(negedge clock);
  endtask
  // ====
  // every select code on one input, the other fields left at zero
  task automatic modes(input int i);
    logic [23:0] f, b, re, fe;
    for (int s = 0; s < 4; s++) begin
      b = 24'h000001 << i;
      f = 24'(s) << (2 * (i % 12));
      re = s[0] ? b : 24'h000000;
      fe = s[1] ? b : 24'h000000;
      sweie_host_model_inst.wr(6'h22, i < 12 ? f : 24'h000000);
      sweie_host_model_inst.wr(6'h23, i < 12 ? 24'h000000 : f);
      rdchk(i < 12 ? 6'h22 : 6'h23, f);
      smp(1'b0, 24'h000000, 24'h000000);
      smp(1'b1, re, 24'h000000);
      smp(1'b0, 24'h000000, fe);
    end
  endtask
  // ====
  // main sequence
  initial begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    rdchk(6'h22, 24'h000000);
    rdchk(6'h23, 24'h000000);
    smp(1'b1, 24'h000000, 24'h000000);
    smp(1'b0, 24'h000000, 24'h000000);
    sweie_host_model_inst.wr(6'h24, 24'hFFFFFF);
    rdchk(6'h24, 24'h000000);
    rdchk(6'h22, 24'h000000);
    modes(0);
    modes(3);
    modes(4);
    modes(6);
    modes(12);
    modes(19);
    modes(23);
    test_done();
  end
  // hang guard: far beyond the length of the main sequence
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    test_done();
  end
endmodule
